// ==== rtl/adc_seq_pkg.sv ====
// shared constants for the converter sequencer: register map, fields, codes, counts
// assumes a 32-bit apb slave with 12-bit byte addresses, one clock domain
package adc_seq_pkg;

  localparam int ADDR_W = 12;

  // register byte offsets
  localparam logic [ADDR_W-1:0] STATUS_CTRL_OFS = 12'h000;
  localparam logic [ADDR_W-1:0] RESULT_OFS = 12'h004;
  localparam logic [ADDR_W-1:0] CLK_DIV_OFS = 12'h008;

  // conversion_status_control fields
  localparam int DONE_BIT = 7;
  localparam int IRQ_EN_BIT = 6;
  localparam int CONT_BIT = 5;
  localparam int SEL_MSB = 4;
  localparam int SEL_LSB = 0;

  // conversion_clock_divider field
  localparam int DIV_MSB = 7;
  localparam int DIV_LSB = 5;

  // values after reset
  localparam logic [4:0] SEL_RESET = 5'h1f;
  localparam logic [2:0] DIV_RESET = 3'h0;
  localparam logic [7:0] RESULT_RESET = 8'h00;

  // input_select codes
  localparam logic [4:0] SEL_LAST_PIN = 5'h03;
  localparam logic [4:0] SEL_RESERVED = 5'h1b;
  localparam logic [4:0] SEL_HIGH_REF = 5'h1d;
  localparam logic [4:0] SEL_LOW_REF = 5'h1e;
  localparam logic [4:0] SEL_POWER_OFF = 5'h1f;

  // conversion sequence, in converter clock steps
  localparam logic [3:0] STEP_SAMPLE = 4'h0;
  localparam logic [3:0] STEP_FIRST_BIT = 4'h1;
  localparam logic [3:0] STEP_LAST_BIT = 4'h8;
  localparam logic [3:0] STEP_LAST = 4'hf;
  localparam logic [7:0] TRIAL_START = 8'h80;
  localparam logic [2:0] BIT_MSB = 3'h7;

  // bus cycles the comparator answer needs through its synchroniser
  localparam logic [1:0] SETTLE_CYCLES = 2'h3;

  // prescaler terminal counts (ratio minus one)
  localparam logic [3:0] DIV1_LAST = 4'h0;
  localparam logic [3:0] DIV2_LAST = 4'h1;
  localparam logic [3:0] DIV4_LAST = 4'h3;
  localparam logic [3:0] DIV8_LAST = 4'h7;
  localparam logic [3:0] DIV16_LAST = 4'hf;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN = 2'b01,
    ST_HALT = 2'b10
  } conv_state_t;

endpackage

// ==== rtl/conv_clock_prescaler.sv ====
// converter clock prescaler: one-cycle tick every 1, 2, 4, 8 or 16 bus clocks
// assumes divide_select comes from a register on the same clock
module conv_clock_prescaler
  import adc_seq_pkg::*;
(
  input wire logic sys_clk, // bus clock
  input wire logic resetn, // async reset, active low
  input wire logic run, // count only while converter is powered
  input wire logic [2:0] divide_select, // clock_divide_select field
  output logic tick // converter clock rising edge, one cycle
);

  typedef struct packed {
    logic [3:0] count;
  } presc_t;

  presc_t s_q;
  presc_t s_d;
  logic [3:0] last;

  function automatic logic [3:0] last_count(input logic [2:0] sel);
    logic [3:0] r;
    r = DIV16_LAST;
    if (!sel[2]) begin
      case (sel[1:0])
        2'b00: r = DIV1_LAST;
        2'b01: r = DIV2_LAST;
        2'b10: r = DIV4_LAST;
        default: r = DIV8_LAST;
      endcase
    end
    return r;
  endfunction

  always_comb begin
    last = last_count(divide_select);
    s_d = s_q;
    tick = run && (s_q.count >= last);
    if (!run || tick) begin
      s_d.count = 4'h0;
    end else begin
      s_d.count = s_q.count + 4'h1;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

endmodule

// ==== rtl/adc_sequencer_control.sv ====
// control logic of an 8-bit four-channel successive-approximation converter
// assumes an apb master on sys_clk, an analog comparator and dac outside,
// and power-mode levels from the core on the same clock
// Function
// - irq enable set: raise interrupt request at every conversion end; reset clears enable
// - irq enable set: done flag never set, always reads zero
// - irq disabled: done set at conversion end, held until result read; reset clears
// - pending interrupt clears on result read or status/control write
// - keeps converting in wait mode; enabled interrupt wakes the processor
// - stop mode aborts conversion and idles; conversions resume after stop
// - continuous bit repeats conversions, else one; reset clears it
// - select codes 0 to 3 route external channels 0 to 3
// - all-ones select powers converter off; reset loads all ones
// - unused or reserved select codes give an undefined result
// - codes 11101 and 11110 connect high and low reference nodes
// - first conversion after power-off is a settling cycle, no result
// - one 8-bit result register updated at each conversion end
// - prescaler divides by 1, 2, 4, 8, or 16 when top bit set
// - conversion is sixteen converter clocks, starting first edge after write; at divide by 1 and 2 the comparator wait stretches each bit
// - continuous mode overwrites the result whether read or not
//
// Decided for this implementation: the APB slave port and the register offsets.
module adc_sequencer_control
  import adc_seq_pkg::*;
(
  input wire logic sys_clk, // bus clock, 40 MHz
  input wire logic resetn, // async reset, active low
  input wire logic [adc_seq_pkg::ADDR_W-1:0] paddr, // apb byte address
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb write
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped address
  input wire logic wait_mode, // core is in wait mode
  input wire logic stop_mode, // core is in stop mode
  input wire logic comp_above, // comparator: input at or above dac level
  output logic [1:0] analog_channel, // external channel number
  output logic channel_enable, // an external channel is routed
  output logic analog_high_reference, // route high reference node
  output logic analog_low_reference, // route low reference node
  output logic converter_power, // analog converter powered
  output logic sample_hold, // sampling analog_sample_input
  output logic [7:0] dac_trial, // successive-approximation trial code
  output logic conv_irq, // conversion interrupt request, level
  output logic wake_request // wakeup from wait mode
);

  typedef struct packed {
    conv_state_t state;
    logic [3:0] step;
    logic [2:0] bit_idx;
    logic [7:0] trial;
    logic [7:0] result;
    logic [1:0] settle;
    logic irq_en;
    logic cont;
    logic [4:0] sel;
    logic [2:0] div;
    logic done;
    logic irq;
    logic warm;
    logic start_pend;
    logic resume;
    logic [1:0] comp_sync;
    logic [31:0] rdata;
    logic slverr;
  } seq_t;

  seq_t s_q;
  seq_t s_d;
  logic tick;
  logic wr_acc;
  logic rd_acc;
  logic setup;
  logic wr_ctrl;
  logic rd_result;
  logic powered;
  logic finish;
  logic comp_now;

  function automatic logic addr_mapped(input logic [ADDR_W-1:0] a);
    return (a == STATUS_CTRL_OFS) || (a == RESULT_OFS) || (a == CLK_DIV_OFS);
  endfunction

  function automatic logic [31:0] read_word(input seq_t s, input logic [ADDR_W-1:0] a);
    logic [31:0] w;
    w = 32'h0000_0000;
    if (a == STATUS_CTRL_OFS) begin
      // the flag is hidden while interrupts are enabled
      w[DONE_BIT] = s.done && !s.irq_en;
      w[IRQ_EN_BIT] = s.irq_en;
      w[CONT_BIT] = s.cont;
      w[SEL_MSB:SEL_LSB] = s.sel;
    end else if (a == RESULT_OFS) begin
      w[7:0] = s.result;
    end else if (a == CLK_DIV_OFS) begin
      w[DIV_MSB:DIV_LSB] = s.div;
    end
    return w;
  endfunction

  conv_clock_prescaler u_prescaler (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .run(powered),
    .divide_select(s_q.div),
    .tick(tick)
  );

  // no wait state: read data is taken in the setup cycle
  assign setup = psel && !penable;
  assign pready = psel && penable;
  assign wr_acc = pready && pwrite && addr_mapped(paddr);
  assign rd_acc = pready && !pwrite && addr_mapped(paddr);
  assign wr_ctrl = wr_acc && (paddr == STATUS_CTRL_OFS);
  assign rd_result = rd_acc && (paddr == RESULT_OFS);
  assign prdata = s_q.rdata;
  assign pslverr = pready && s_q.slverr;

  assign powered = (s_q.sel != SEL_POWER_OFF) && !stop_mode;
  assign comp_now = s_q.comp_sync[1];

  always_comb begin
    s_d = s_q;
    finish = 1'b0;

    // two-stage synchroniser for the asynchronous comparator
    s_d.comp_sync = {s_q.comp_sync[0], comp_above};

    if (setup) begin
      s_d.rdata = read_word(s_q, paddr);
      s_d.slverr = !addr_mapped(paddr);
    end

    if (s_q.settle != 2'h0) begin
      s_d.settle = s_q.settle - 2'h1;
    end

    // conversion sequencer
    case (s_q.state)
      ST_IDLE: begin
        if (stop_mode) begin
          s_d.state = ST_HALT;
        end else if (s_q.start_pend && tick) begin
          s_d.state = ST_RUN;
          s_d.start_pend = 1'b0;
          s_d.step = STEP_SAMPLE;
        end
      end
      ST_RUN: begin
        if (stop_mode) begin
          // cut conversion is rerun once the core leaves stop
          s_d.state = ST_HALT;
          s_d.resume = 1'b1;
        end else if (!powered) begin
          s_d.state = ST_IDLE;
        end else if (tick && (s_q.settle == 2'h0)) begin
          if (s_q.step == STEP_SAMPLE) begin
            s_d.trial = TRIAL_START;
            s_d.bit_idx = BIT_MSB;
            s_d.settle = SETTLE_CYCLES;
          end else if (s_q.step <= STEP_LAST_BIT) begin
            // keep the trial bit only if the input is at or above it
            s_d.trial[s_q.bit_idx] = comp_now;
            if (s_q.bit_idx != 3'h0) begin
              s_d.trial[s_q.bit_idx - 3'h1] = 1'b1;
              s_d.bit_idx = s_q.bit_idx - 3'h1;
              s_d.settle = SETTLE_CYCLES;
            end
          end
          if (s_q.step == STEP_LAST) begin
            s_d.state = ST_IDLE;
            if (s_q.warm) begin
              // settling run after power-up: discard and go again
              s_d.warm = 1'b0;
              s_d.start_pend = 1'b1;
            end else begin
              finish = 1'b1;
              s_d.start_pend = s_q.cont;
            end
          end else begin
            s_d.step = s_q.step + 4'h1;
          end
        end
      end
      ST_HALT: begin
        if (!stop_mode) begin
          s_d.state = ST_IDLE;
          s_d.start_pend = s_q.resume || s_q.cont || s_q.start_pend;
          s_d.resume = 1'b0;
        end
      end
      default: begin
        s_d.state = ST_IDLE;
      end
    endcase

    // power-off aborts any run and arms the settling cycle
    if (s_q.sel == SEL_POWER_OFF) begin
      s_d.warm = 1'b1;
    end

    // register writes
    if (wr_ctrl) begin
      s_d.irq_en = pwdata[IRQ_EN_BIT];
      s_d.cont = pwdata[CONT_BIT];
      s_d.sel = pwdata[SEL_MSB:SEL_LSB];
      // a write restarts the sequence on the next converter edge unless it selects power-off
      if (pwdata[SEL_MSB:SEL_LSB] != SEL_POWER_OFF) begin
        s_d.start_pend = 1'b1;
      end else begin
        s_d.start_pend = 1'b0;
      end
      if (s_q.state == ST_RUN) begin
        s_d.state = ST_IDLE;
      end else if (s_q.state == ST_HALT) begin
        s_d.resume = 1'b0;
        s_d.state = ST_HALT;
      end
    end
    if (wr_acc && (paddr == CLK_DIV_OFS)) begin
      s_d.div = pwdata[DIV_MSB:DIV_LSB];
    end

    // clears first, so that a completion in the same cycle wins
    if (wr_ctrl || rd_result) begin
      s_d.irq = 1'b0;
    end
    if (rd_result) begin
      s_d.done = 1'b0;
    end
    if (finish) begin
      s_d.result = s_q.trial;
      if (s_q.irq_en) begin
        s_d.irq = 1'b1;
      end else begin
        s_d.done = 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      s_q.state <= ST_IDLE;
      s_q.step <= STEP_SAMPLE;
      s_q.bit_idx <= BIT_MSB;
      s_q.trial <= RESULT_RESET;
      s_q.result <= RESULT_RESET;
      s_q.settle <= 2'h0;
      s_q.irq_en <= 1'b0;
      s_q.cont <= 1'b0;
      s_q.sel <= SEL_RESET;
      s_q.div <= DIV_RESET;
      s_q.done <= 1'b0;
      s_q.irq <= 1'b0;
      s_q.warm <= 1'b1;
      s_q.start_pend <= 1'b0;
      s_q.resume <= 1'b0;
      s_q.comp_sync <= 2'b00;
      s_q.rdata <= 32'h0000_0000;
      s_q.slverr <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  // analog routing, decoded from the select register
  always_comb begin
    analog_channel = s_q.sel[1:0];
    channel_enable = (s_q.sel <= SEL_LAST_PIN);
    analog_high_reference = (s_q.sel == SEL_HIGH_REF);
    analog_low_reference = (s_q.sel == SEL_LOW_REF);
    // unused and reserved codes route nothing; the result is then meaningless
    if (s_q.sel == SEL_RESERVED) begin
      channel_enable = 1'b0;
    end
  end

  assign converter_power = powered;
  assign sample_hold = (s_q.state == ST_RUN) && (s_q.step == STEP_SAMPLE);
  assign dac_trial = s_q.trial;
  assign conv_irq = s_q.irq;
  // wait mode gates nothing in the sequencer, only the wakeup
  assign wake_request = s_q.irq && wait_mode;

endmodule

// ==== tb/adc_seq_props.sv ====
// port assertions for the converter sequencer
// assumes binding into adc_sequencer_control, one clock domain
module adc_seq_props
  import adc_seq_pkg::*;
(
  input wire logic sys_clk, // clock
  input wire logic resetn, // reset
  input wire logic [adc_seq_pkg::ADDR_W-1:0] paddr, // address
  input wire logic psel, // select
  input wire logic penable, // access
  input wire logic pwrite, // write
  input wire logic [31:0] pwdata, // wdata
  input wire logic [31:0] prdata, // rdata
  input wire logic wait_mode, // wait
  input wire logic stop_mode, // stop
  input wire logic [1:0] analog_channel, // pin
  input wire logic channel_enable, // pin on
  input wire logic analog_high_reference, // high node
  input wire logic analog_low_reference, // low node
  input wire logic converter_power, // power
  input wire logic sample_hold, // sampling
  input wire logic conv_irq, // irq
  input wire logic wake_request // wake
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  logic irq_en_q;
  logic cont_q;
  logic [4:0] sel_q;
  sequence ctrl_wr;
    psel && penable && pwrite && paddr == STATUS_CTRL_OFS;
  endsequence
  sequence res_rd;
    psel && penable && !pwrite && paddr == RESULT_OFS;
  endsequence
  // shadow of the control fields, updated on the same edge as the design
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      irq_en_q <= 1'b0;
      cont_q <= 1'b0;
      sel_q <= SEL_RESET;
    end else if (psel && penable && pwrite && paddr == STATUS_CTRL_OFS) begin
      irq_en_q <= pwdata[IRQ_EN_BIT];
      cont_q <= pwdata[CONT_BIT];
      sel_q <= pwdata[SEL_MSB:SEL_LSB];
    end
  end
  a_wake_in_wait: assert property (wake_request == (conv_irq && wait_mode))
    else $error("wake request mismatch");
  a_read_clears_irq: assert property (res_rd ##0 !cont_q |=> !conv_irq)
    else $error("irq kept after result read");
  a_write_clears_irq: assert property (ctrl_wr |=> !conv_irq)
    else $error("irq kept after control write");
  a_irq_needs_enable: assert property ($rose(conv_irq) |-> irq_en_q)
    else $error("irq raised while disabled");
  a_done_reads_zero: assert property (psel && penable && !pwrite &&
    paddr == STATUS_CTRL_OFS && irq_en_q |-> !prdata[DONE_BIT])
    else $error("done bit set in irq mode");
  a_power_gate: assert property
    (converter_power == (sel_q != SEL_POWER_OFF && !stop_mode))
    else $error("converter power mismatch");
  a_pin_route: assert property (channel_enable == (sel_q <= SEL_LAST_PIN) &&
    (!channel_enable || analog_channel == sel_q[1:0]))
    else $error("pin routing mismatch");
  a_ref_route: assert property (analog_high_reference == (sel_q == SEL_HIGH_REF) &&
    analog_low_reference == (sel_q == SEL_LOW_REF))
    else $error("reference routing mismatch");
  a_stop_idles: assert property (stop_mode [*2] |-> !sample_hold)
    else $error("sampling during stop");
endmodule

bind adc_sequencer_control adc_seq_props u_props (.sys_clk, .resetn, .paddr, .psel,
  .penable, .pwrite, .pwdata, .prdata, .wait_mode, .stop_mode, .analog_channel,
  .channel_enable, .analog_high_reference, .analog_low_reference, .converter_power,
  .sample_hold, .conv_irq, .wake_request);

// ==== tb/analog_front_model.sv ====
// analog side stand-in: pin levels, reference nodes, comparator
// assumes pin_levels holds four 8-bit input codes, held steady by the bench
module analog_front_model (
  input wire logic [31:0] pin_levels, // four levels
  input wire logic [1:0] analog_channel, // pin number
  input wire logic channel_enable, // pin routed
  input wire logic analog_high_reference, // high node
  input wire logic analog_low_reference, // low node
  input wire logic [7:0] dac_trial, // trial code
  output logic comp_above // input at or above trial
);
  logic [7:0] level;
  always_comb begin
    level = dac_trial ^ 8'h01; // unused codes: a level that keeps moving
    if (channel_enable) level = pin_levels[8*analog_channel +: 8];
    if (analog_high_reference) level = 8'hff;
    if (analog_low_reference) level = 8'h00;
  end
  assign comp_above = level >= dac_trial;
endmodule

// ==== tb/adc_sequencer_control_test.sv ====
// self-checking bench for the converter sequencer
// assumes the analog model on the far side and the bound port checker
module adc_sequencer_control_test;
  timeunit 1ns;
  timeprecision 100ps;
  import adc_seq_pkg::*;
  logic sys_clk = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic wait_mode = 1'b0, stop_mode = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, pin_levels, rd;
  logic pready, pslverr, comp_above, channel_enable, analog_high_reference, err;
  logic analog_low_reference, converter_power, sample_hold, conv_irq, wake_request;
  logic [1:0] analog_channel;
  logic [7:0] dac_trial;
  logic [4:0] sels[6] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h1d, 5'h1e};
  int num_errors = 0, samples_checked = 0, cycles = 0, n;
  int exp_q[$];
  always #12.5 sys_clk = ~sys_clk;
  adc_sequencer_control dut (.sys_clk, .resetn, .paddr, .psel, .penable, .pwrite, .pwdata,
    .prdata, .pready, .pslverr, .wait_mode, .stop_mode, .comp_above, .analog_channel,
    .channel_enable, .analog_high_reference, .analog_low_reference, .converter_power,
    .sample_hold, .dac_trial, .conv_irq, .wake_request);
  analog_front_model far_side (.pin_levels, .analog_channel, .channel_enable,
    .analog_high_reference, .analog_low_reference, .dac_trial, .comp_above);
  // read data taken at the completing edge itself, no race with the task
  always @(posedge sys_clk) begin
    if (psel && penable && pready) begin
      rd <= prdata;
      err <= pslverr;
    end
  end
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 60000) begin
      num_errors++;
      wrap_up();
    end
  end
  task automatic wrap_up();
    if (num_errors == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    // unused upper bits get noise; the done bit is never written as one
    pwdata <= {24'($urandom()), (a == STATUS_CTRL_OFS) ? (d & 8'h7f) : d};
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic wait_irq();
    n = 0;
    while (conv_irq !== 1'b1 && n < 4000) begin
      @(posedge sys_clk);
      n++;
    end
    chk("irq raised", {31'd0, conv_irq}, 32'd1);
  endtask
  task automatic read_result();
    apb(0, RESULT_OFS, 0);
    chk("result", rd, exp_q.pop_front());
  endtask
  initial begin
    void'($urandom(32'hf578afd2));
    pin_levels = $urandom();
    repeat (4) @(posedge sys_clk);
    resetn <= 1'b1;
    @(posedge sys_clk);
    apb(0, STATUS_CTRL_OFS, 0);
    chk("status reset", rd, 32'h0000_001f);
    apb(0, CLK_DIV_OFS, 0);
    chk("divider reset", rd, 0);
    apb(0, 12'h00c, 0);
    chk("unmapped read", rd, 0);
    chk("unmapped error", {31'd0, err}, 1);
    foreach (sels[i]) begin
      // alternate divide by 1 and divide by 2, where the comparator wait stretches each bit in both
      apb(1, CLK_DIV_OFS, {2'b00, i[0], 5'h00});
      chk("mapped error", {31'd0, err}, 0);
      apb(1, STATUS_CTRL_OFS, {3'b010, sels[i]});
      exp_q.push_back(sels[i] < 4 ? pin_levels[8*sels[i] +: 8] : sels[i] == 5'h1d ? 255 : 0);
      wait_irq();
      apb(0, STATUS_CTRL_OFS, 0);
      chk("status irq mode", rd, {3'b010, sels[i]});
      read_result();
    end
    apb(1, STATUS_CTRL_OFS, 8'h01);
    exp_q.push_back(pin_levels[15:8]);
    n = 0;
    do begin
      apb(0, STATUS_CTRL_OFS, 0);
      n++;
    end while (rd[7] !== 1'b1 && n < 300);
    chk("done set", rd, 32'h0000_0081);
    chk("no irq", {31'd0, conv_irq}, 0);
    read_result();
    repeat (600) @(posedge sys_clk);
    apb(0, STATUS_CTRL_OFS, 0);
    chk("done cleared, single run", rd, 32'h0000_0001);
    for (int c = 2; c < 8; c++) begin
      apb(1, CLK_DIV_OFS, 8'(c << 5));
      apb(0, CLK_DIV_OFS, 0);
      chk("divider", rd, c << 5);
      // after the first pass, cuts the running conversion; its data is never compared
      apb(1, STATUS_CTRL_OFS, 8'h62);
      wait_irq();
      apb(0, RESULT_OFS, 0);
      wait_irq();
      // sixteen ticks of conversion plus the start tick of the next run
      chk("period", n + 3, 17 * (c[2] ? 16 : 1 << c));
    end
    apb(1, STATUS_CTRL_OFS, 8'h42);
    exp_q.push_back(pin_levels[23:16]);
    repeat (100) @(posedge sys_clk);
    stop_mode <= 1'b1;
    repeat (600) @(posedge sys_clk);
    chk("irq in stop", {31'd0, conv_irq}, 0);
    stop_mode <= 1'b0;
    wait_irq();
    read_result();
    wait_mode <= 1'b1;
    apb(1, STATUS_CTRL_OFS, 8'h43);
    exp_q.push_back(pin_levels[31:24]);
    wait_irq();
    chk("wake", {31'd0, wake_request}, 1);
    read_result();
    apb(1, STATUS_CTRL_OFS, 8'h5f);
    repeat (600) @(posedge sys_clk);
    chk("off irq", {31'd0, conv_irq}, 0);
    chk("off power", {31'd0, converter_power}, 0);
    chk("off no wake", {31'd0, wake_request}, 0);
    wait_mode <= 1'b0;
    apb(1, STATUS_CTRL_OFS, 8'h40);
    exp_q.push_back(pin_levels[7:0]);
    wait_irq();
    chk("settling run", {31'd0, n > 300}, 1);
    read_result();
    wrap_up();
  end
endmodule
